// >>> rtl/ssc_defs.svh
// constants for the sram sleep and stall control block
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_ADDR_W            18
`define SSC_LANE_W            9
`define SSC_LANES             4
`define SSC_DATA_W            36
`define SSC_LANES_IDLE        4'hF
`define SSC_CNT_RST           2'h0
`define SSC_ORDER_LINEAR      1'b0
`define SSC_CLK_PERIOD_NS     50
`define SSC_SLEEP_WIN_PERIODS 2
`define SSC_SLEEP_WIN_NS      (`SSC_SLEEP_WIN_PERIODS * `SSC_CLK_PERIOD_NS)
`define SSC_SLEEP_WIN_CYC     (`SSC_SLEEP_WIN_NS / `SSC_CLK_PERIOD_NS)
`endif

// >>> rtl/ssc_pkg.sv
// types of the sram sleep and stall control block
package ssc_pkg;
  `include "ssc_defs.svh"

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`SSC_LANES-1:0]   lane_n;
    logic [`SSC_ADDR_W-1:0]  addr;
    logic [`SSC_DATA_W-1:0]  wdata;
  } ssc_cmd_t;

  typedef struct packed {
    logic                    sleep_s1;
    logic                    sleep_q;
    logic                    oe_s1;
    logic                    oe_n_q;
    logic                    mode_s1;
    logic                    mode_q;
    logic                    sel_q;
    logic                    wr_q;
    logic [`SSC_ADDR_W-1:0]  base;
    logic [1:0]              cnt;
    ssc_cmd_t                cmd;
    ssc_cmd_t                pend;
    logic [`SSC_DATA_W-1:0]  rdata;
    logic                    data_oe;
  } ssc_state_t;
endpackage

// >>> rtl/ssc_mem_array.sv
// storage array with per-lane synchronous write and combinational read
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_mem_array
  import ssc_pkg::*;
#(
  parameter int AW = `SSC_ADDR_W
) (
  input  wire logic                   core_clk_i,
  input  wire logic [`SSC_LANES-1:0]  lane_we_i,
  input  wire logic [AW-1:0]          waddr_i,
  input  wire logic [`SSC_DATA_W-1:0] wdata_i,
  input  wire logic [AW-1:0]          raddr_i,
  output logic      [`SSC_DATA_W-1:0] rdata_o
);
  if (AW < 1 || AW > `SSC_ADDR_W) begin : g_chk
    $error("ssc_mem_array: AW out of range");
  end

  // one array per lane so that every lane has a single writer
  for (genvar l = 0; l < `SSC_LANES; l++) begin : g_lane
    logic [`SSC_LANE_W-1:0] mem [2**AW];

    always_ff @(posedge core_clk_i) begin
      if (lane_we_i[l]) begin
        mem[waddr_i] <= wdata_i[l*`SSC_LANE_W +: `SSC_LANE_W];
      end
    end

    assign rdata_o[l*`SSC_LANE_W +: `SSC_LANE_W] = mem[raddr_i];
  end
endmodule

// >>> rtl/ssc_core.sv
// pipelined sram control: sleep, select, burst, stall, coherency
// Functional notes
// - while sleep request is high the device acts deselected
// - in sleep all inputs but sleep request and clock hold are ignored, data undriven
// - sleep request is an asynchronous active-high input
// - sampling stops within two clock periods after sleep request rises
// - sampling resumes within two periods after it falls; controller waits
// - burst order pin low gives linear, high gives interleaved
// - selected only when both low selects low and high select high
// - reads of data still in the input data register return it
// - edges with clock hold high are stalls; no write happens
// - output enable does not affect writes
// - new address captured only on load edges while selected
// - linear counts low two bits up; interleaved xors start with count
// - burst counter advances on every unstalled selected advance cycle
// - low byte enables write their lanes; all high aborts the write
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_core
  import ssc_pkg::*;
#(
  parameter int MEM_AW = `SSC_ADDR_W
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   sleep_request_i,
  input  wire logic                   clock_hold_n_i,
  input  wire logic                   chip_select_n_i,
  input  wire logic                   chip_select_second_n_i,
  input  wire logic                   chip_select_hi_i,
  input  wire logic                   load_advance_i,
  input  wire logic                   read_write_i,
  input  wire logic                   byte_lane_a_write_n_i,
  input  wire logic                   byte_lane_b_write_n_i,
  input  wire logic                   byte_lane_c_write_n_i,
  input  wire logic                   byte_lane_d_write_n_i,
  input  wire logic                   burst_order_i,
  input  wire logic                   out_en_n_i,
  input  wire logic [`SSC_ADDR_W-1:0] addr_i,
  input  wire logic [`SSC_DATA_W-1:0] wdata_i,
  output logic      [`SSC_DATA_W-1:0] read_data_o,
  output logic                        data_oe_o,
  output logic                        sleep_active_o
);
  localparam int SLP_CYC = `SSC_SLEEP_WIN_CYC;

  if (MEM_AW < 2 || MEM_AW > `SSC_ADDR_W) begin : g_chk
    $error("ssc_core: MEM_AW out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic sel_ok(input logic cs_n, input logic cs2_n,
                                  input logic cs_hi);
    return !cs_n && !cs2_n && cs_hi;
  endfunction

  function automatic logic [`SSC_ADDR_W-1:0] burst_addr(
      input logic [`SSC_ADDR_W-1:0] base, input logic [1:0] cnt,
      input logic mode);
    logic [`SSC_ADDR_W-1:0] a;
    a = base;
    if (mode == `SSC_ORDER_LINEAR) begin
      a[1:0] = base[1:0] + cnt;
    end else begin
      a[1:0] = base[1:0] ^ cnt;
    end
    return a;
  endfunction

  function automatic logic [`SSC_DATA_W-1:0] lane_merge(
      input logic [`SSC_DATA_W-1:0] old_d, input logic [`SSC_DATA_W-1:0] new_d,
      input logic [`SSC_LANES-1:0] lane_n);
    logic [`SSC_DATA_W-1:0] m;
    m = old_d;
    for (int l = 0; l < `SSC_LANES; l++) begin
      if (!lane_n[l]) begin
        m[l*`SSC_LANE_W +: `SSC_LANE_W] = new_d[l*`SSC_LANE_W +: `SSC_LANE_W];
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  ssc_state_t             st_q;
  ssc_state_t             st_d;
  logic [`SSC_LANES-1:0]  lanes_n;
  logic                   stall;
  logic                   go;
  logic                   commit;
  logic [`SSC_DATA_W-1:0] mem_rdata;
  logic [1:0]             cnt_nx;

  assign lanes_n = {byte_lane_d_write_n_i, byte_lane_c_write_n_i,
                    byte_lane_b_write_n_i, byte_lane_a_write_n_i};
  assign stall   = clock_hold_n_i;
  assign go      = !stall && !st_q.sleep_q;
  assign commit  = st_q.pend.valid && !stall;
  assign cnt_nx  = st_q.cnt + 2'h1;

  ssc_mem_array #(
    .AW (MEM_AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .lane_we_i  (commit ? ~st_q.pend.lane_n : '0),
    .waddr_i    (st_q.pend.addr[MEM_AW-1:0]),
    .wdata_i    (st_q.pend.wdata),
    .raddr_i    (st_q.cmd.addr[MEM_AW-1:0]),
    .rdata_o    (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    // async pins pass two flops; sleep gating comes from the second
    st_d.sleep_s1 = sleep_request_i;
    st_d.sleep_q  = st_q.sleep_s1;
    st_d.oe_s1    = out_en_n_i;
    st_d.oe_n_q   = st_q.oe_s1;
    st_d.mode_s1  = burst_order_i;
    st_d.mode_q   = st_q.mode_s1;
    if (commit) begin
      st_d.pend.valid = 1'b0;
    end
    if (st_q.sleep_q) begin
      st_d.sel_q     = 1'b0;
      st_d.cmd.valid = 1'b0;
      st_d.data_oe   = 1'b0;
    end else if (!stall) begin
      // execute the command taken at the previous edge
      st_d.data_oe = 1'b0;
      if (st_q.cmd.valid && st_q.cmd.write) begin
        if (st_q.cmd.lane_n != `SSC_LANES_IDLE) begin
          st_d.pend = st_q.cmd;
        end
      end else if (st_q.cmd.valid) begin
        st_d.rdata = mem_rdata;
        if (st_q.pend.valid && st_q.pend.addr == st_q.cmd.addr) begin
          st_d.rdata = lane_merge(mem_rdata, st_q.pend.wdata,
                                  st_q.pend.lane_n);
        end
        st_d.data_oe = !st_q.oe_n_q;
      end
      // take the command on the pins
      st_d.cmd.wdata  = wdata_i;
      st_d.cmd.lane_n = lanes_n;
      if (!load_advance_i) begin
        st_d.sel_q     = sel_ok(chip_select_n_i, chip_select_second_n_i,
                                chip_select_hi_i);
        st_d.cmd.valid = st_d.sel_q;
        if (st_d.sel_q) begin
          st_d.base      = addr_i;
          st_d.cnt       = `SSC_CNT_RST;
          st_d.wr_q      = !read_write_i;
          st_d.cmd.addr  = addr_i;
          st_d.cmd.write = !read_write_i;
        end
      end else begin
        st_d.cmd.valid = st_q.sel_q;
        if (st_q.sel_q) begin
          st_d.cnt       = cnt_nx;
          st_d.cmd.addr  = burst_addr(st_q.base, cnt_nx, st_q.mode_q);
          st_d.cmd.write = st_q.wr_q;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
      st_q.cmd.lane_n  <= `SSC_LANES_IDLE;
      st_q.pend.lane_n <= `SSC_LANES_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign read_data_o    = st_q.rdata;
  assign data_oe_o      = st_q.data_oe;
  assign sleep_active_o = st_q.sleep_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_sel_load;
    !stall && !st_q.sleep_q && !load_advance_i &&
      sel_ok(chip_select_n_i, chip_select_second_n_i, chip_select_hi_i);
  endsequence

  sequence s_advance;
    go && load_advance_i && st_q.sel_q;
  endsequence

  sequence s_pend_hit;
    go && st_q.cmd.valid && !st_q.cmd.write && st_q.pend.valid &&
      st_q.pend.addr == st_q.cmd.addr && st_q.pend.lane_n == '0;
  endsequence

  AST_SLEEP_DESELECT: assert property (
    st_q.sleep_q |=> !st_q.cmd.valid && !st_q.sel_q)
    else $error("command taken while asleep");

  AST_SLEEP_HIGHZ: assert property (
    st_q.sleep_q |=> (!data_oe_o) [*2])
    else $error("data driven during sleep");

  AST_SLEEP_ENTRY: assert property (
    $rose(sleep_request_i) |-> ##[1:SLP_CYC] sleep_active_o)
    else $error("sleep entry slower than two periods");

  AST_SLEEP_EXIT: assert property (
    $fell(sleep_request_i) |-> ##[1:SLP_CYC] !sleep_active_o)
    else $error("sleep exit slower than two periods");

  AST_STALL_HOLD: assert property (
    (stall && st_q.pend.valid) |=>
      st_q.pend.valid && $stable(st_q.pend) && $stable(st_q.cnt))
    else $error("state moved on a stall edge");

  AST_LOAD_ADDR: assert property (
    s_sel_load |=> st_q.cmd.valid && st_q.cmd.addr == $past(addr_i) &&
      st_q.cnt == `SSC_CNT_RST)
    else $error("load did not capture address");

  AST_DESELECT: assert property (
    (go && !load_advance_i && chip_select_hi_i == 1'b0) |=>
      !st_q.cmd.valid)
    else $error("selected with high select low");

  AST_BURST_ADDR: assert property (
    s_advance |=> st_q.cnt == $past(cnt_nx) && st_q.cmd.addr[1:0] ==
      ($past(st_q.mode_q) ? ($past(st_q.base[1:0]) ^ st_q.cnt)
                          : 2'($past(st_q.base[1:0]) + st_q.cnt)))
    else $error("burst address out of order");

  AST_COHERENT: assert property (
    s_pend_hit |=> read_data_o == $past(st_q.pend.wdata))
    else $error("read missed input data register");

  AST_WRITE_ABORT: assert property (
    (go && st_q.cmd.valid && st_q.cmd.write &&
      st_q.cmd.lane_n == `SSC_LANES_IDLE && !commit) |=>
      !st_q.pend.valid)
    else $error("aborted write was queued");
endmodule

// >>> dv/ssc_ctrl_model.sv
// memory controller model that drives the sram command pins
`timescale 1ns/1ps
`include "ssc_defs.svh"
module ssc_ctrl_model (
  input  wire logic                   core_clk_i,
  output logic                        sleep_request_o,
  output logic                        clock_hold_n_o,
  output logic [2:0]                  sel_o,
  output logic                        load_advance_o,
  output logic                        read_write_o,
  output logic [3:0]                  lane_n_o,
  output logic                        burst_order_o,
  output logic                        out_en_n_o,
  output logic [`SSC_ADDR_W-1:0]      addr_o,
  output logic [`SSC_DATA_W-1:0]      wdata_o
);
  //////////////////////////////////////////////////////////////////////////
  initial begin
    sleep_request_o = 1'b0;
    clock_hold_n_o = 1'b0;
    sel_o = 3'b101;
    load_advance_o = 1'b0;
    read_write_o = 1'b1;
    lane_n_o = 4'hF;
    burst_order_o = 1'b0;
    out_en_n_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one command a cycle, driven after the edge and held to the next one
  task automatic op(input logic [2:0] s, input logic ld, rw, hold,
                    input logic [3:0] ln,
                    input logic [`SSC_ADDR_W-1:0] a,
                    input logic [`SSC_DATA_W-1:0] d);
    sel_o = s;
    load_advance_o = ld;
    read_write_o = rw;
    clock_hold_n_o = hold;
    lane_n_o = ln;
    addr_o = a;
    wdata_o = d;
    @(posedge core_clk_i);
    #5;
  endtask
  // deselect cycle; address and data lines show the inverse of their last value
  task automatic idle;
    op(3'b101, 1'b0, 1'b1, 1'b0, 4'hF, ~addr_o, ~wdata_o);
  endtask
  // entry waits two idle cycles so that nothing is in flight
  task automatic set_sleep(input logic on);
    if (on) begin
      idle();
      idle();
    end
    sleep_request_o = on;
  endtask
endmodule

// >>> dv/sync_sram_sleep_stall_control_bench.sv
// self-checking bench for the sram sleep and stall control block
`timescale 1ns/1ps
`include "ssc_defs.svh"
`define CHK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_fail++; $display("wrong value at %0t: %h vs %h", $time, got, exp); \
  end end
module sync_sram_sleep_stall_control_bench;
  import ssc_pkg::*;
  localparam logic [2:0]  SEL  = 3'b001;
  localparam logic [35:0] BASE = 36'h1_2345_6780;
  logic                   core_clk_i;
  logic                   reset_n_i;
  logic                   slp_req, hold_n, ld, rw, mode, oe_n, doe, slp;
  logic [2:0]             sel;
  logic [3:0]             ln;
  logic [`SSC_ADDR_W-1:0] addr;
  logic [`SSC_DATA_W-1:0] wdata, rdata;
  int                     n_fail;
  int                     tests_run;
  //////////////////////////////////////////////////////////////////////////
  ssc_ctrl_model u_ctrl (.core_clk_i(core_clk_i), .sleep_request_o(slp_req),
    .clock_hold_n_o(hold_n), .sel_o(sel), .load_advance_o(ld),
    .read_write_o(rw), .lane_n_o(ln), .burst_order_o(mode),
    .out_en_n_o(oe_n), .addr_o(addr), .wdata_o(wdata));
  ssc_core #(.MEM_AW(8)) u_dut (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .sleep_request_i(slp_req),
    .clock_hold_n_i(hold_n), .chip_select_n_i(sel[2]),
    .chip_select_second_n_i(sel[1]), .chip_select_hi_i(sel[0]),
    .load_advance_i(ld), .read_write_i(rw),
    .byte_lane_a_write_n_i(ln[0]), .byte_lane_b_write_n_i(ln[1]),
    .byte_lane_c_write_n_i(ln[2]), .byte_lane_d_write_n_i(ln[3]),
    .burst_order_i(mode), .out_en_n_i(oe_n), .addr_i(addr),
    .wdata_i(wdata), .read_data_o(rdata), .data_oe_o(doe),
    .sleep_active_o(slp));
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [17:0] a, input logic [35:0] d,
                    input logic [3:0] lanes);
    u_ctrl.op(SEL, 1'b0, 1'b0, 1'b0, lanes, a, d);
  endtask
  task automatic rd_chk(input logic [17:0] a, input logic [35:0] e);
    u_ctrl.op(SEL, 1'b0, 1'b1, 1'b0, 4'hF, a, '0);
    u_ctrl.idle();
    `CHK_EQ(rdata, e)
    `CHK_EQ(doe, 1'b1)
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (2000) @(posedge core_clk_i);
    n_fail++;
    give_verdict();
  end
  initial begin
    logic [35:0] e;
    n_fail = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #5 reset_n_i = 1'b1;
    for (int i = 0; i < 4; i++) wr(18'(18'h20 + i), BASE + i, 4'h0);
    rd_chk(18'h23, BASE + 3);
    wr(18'h30, '0, 4'h0);
    e = '0;
    for (int l = 0; l < 4; l++) begin
      wr(18'h30, '1, ~(4'h1 << l));
      e = e | (36'h1FF << (9 * l));
      rd_chk(18'h30, e);
    end
    wr(18'h30, '0, 4'hF);
    u_ctrl.op(SEL, 1'b0, 1'b0, 1'b1, 4'h0, 18'h30, '0);
    rd_chk(18'h30, e);
    // a pending write survives a stall edge; the stalled write is lost
    wr(18'h32, BASE, 4'h0);
    u_ctrl.idle();
    u_ctrl.op(SEL, 1'b0, 1'b0, 1'b1, 4'h0, 18'h32, ~BASE);
    rd_chk(18'h32, BASE);
    u_ctrl.out_en_n_o = 1'b1;
    wr(18'h31, BASE, 4'h0);
    u_ctrl.out_en_n_o = 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_ctrl.op(SEL ^ (3'b100 >> i), 1'b0, 1'b0, 1'b0, 4'h0, 18'h31,
                ~BASE);
    end
    rd_chk(18'h31, BASE);
    for (int m = 0; m < 2; m++) begin
      u_ctrl.burst_order_o = m[0];
      repeat (3) u_ctrl.idle();
      for (int k = 0; k < 5; k++) begin
        if (k < 4) begin
          u_ctrl.op(SEL, k != 0, 1'b1, 1'b0, 4'hF, 18'h21, '0);
        end else begin
          u_ctrl.idle();
        end
        if (k > 0) begin
          `CHK_EQ(rdata, BASE + (m ? (1 ^ (k - 1)) : (k & 3)))
        end
      end
    end
    u_ctrl.set_sleep(1'b1);
    repeat (2) u_ctrl.idle();
    `CHK_EQ(slp, 1'b1)
    wr(18'h31, ~BASE, 4'h0);
    u_ctrl.op(SEL, 1'b0, 1'b1, 1'b0, 4'hF, 18'h31, '0);
    // a read taken in sleep would drive data at this edge
    u_ctrl.idle();
    `CHK_EQ(doe, 1'b0)
    u_ctrl.set_sleep(1'b0);
    repeat (2) u_ctrl.idle();
    `CHK_EQ(slp, 1'b0)
    rd_chk(18'h31, BASE);
    give_verdict();
  end
endmodule
